// file: design/rst_seq_pkg.sv
// Package for the processor reset sequencer: timing counts, states, carriers.
// Assumes one 10 MHz system clock and synchronous active-low reset.
// Contract
// - Low hard reset aborts current instruction and clears all on-chip state.
// - After hard reset rises, execution starts at address zero.
// - While hard reset is low, only idle cycles, never an instruction fetch.
// - Reset out follows hard reset, releases after it and before first fetch.
// - Reset out also asserts for sleep, watchdog and pin-triggered soft resets.
// - Test-port transfers are timed against the host-driven test clock.
// - After any reset, multiplexed pins become inputs with input buffers disabled.
package rst_seq_pkg;

  // Clock rate and release timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned OUT_HOLD_NS = 200;
  localparam int unsigned OUT_HOLD_CYC = (OUT_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
  localparam int unsigned GPIO_COUNT = 81;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_HELD = 4'h1,
    ST_RELEASE = 4'h2,
    ST_RUN = 4'h4,
    ST_SOFT = 4'h8
  } seq_state_e;

  // Soft reset requests from sleep, watchdog and pin sources
  typedef struct packed {
    logic sleep;
    logic watchdog;
    logic pin;
  } soft_req_s;

  // Core control handed to the processor
  typedef struct packed {
    logic core_reset;
    logic fetch_enable;
    logic [31:0] fetch_addr;
  } core_ctl_s;

endpackage

// file: design/rst_sync.sv
// Two-stage synchroniser for the hard reset level.
// Assumes the input may change at any time relative to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module rst_sync #(
  parameter int unsigned STAGES = 2
) (
  // Clock
  input wire logic clk_sys,
  // Asynchronous level in, synchronised level out
  input wire logic async_in,
  output logic sync_out
);

  logic [STAGES-1:0] chain_r;

  // Shift chain; only the last stage is read outside
  always_ff @(posedge clk_sys)
  begin
    chain_r <= {chain_r[STAGES-2:0], async_in};
  end

  assign sync_out = chain_r[STAGES-1];

endmodule
`default_nettype wire

// file: design/rst_seq.sv
// Reset sequencer: takes the board hard reset, soft reset requests and drives
// core reset, fetch permission, reset-out pin, GPIO safe state and test port readiness.
// Assumes hard_reset_n is held low by the supervisor until power is stable.
`timescale 1ns/1ns
`default_nettype none
module rst_seq #(
  parameter int unsigned HOLD_CYC = rst_seq_pkg::OUT_HOLD_CYC,
  parameter int unsigned NGPIO = rst_seq_pkg::GPIO_COUNT
) (
  // Clock and local synchronous reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Board reset
  input wire logic hard_reset_n,
  // Soft reset sources
  input wire rst_seq_pkg::soft_req_s soft_req,
  // Core control
  output var rst_seq_pkg::core_ctl_s core_ctl,
  input wire logic fetch_start,
  // Reset-out pin
  output logic system_reset_out_n,
  // GPIO safe-state control
  output logic [NGPIO-1:0] gpio_dir_out,
  output logic [NGPIO-1:0] gpio_inbuf_en,
  output logic gpio_force_safe,
  // Test port reset, test clock and readiness
  input wire logic trst_n,
  input wire logic tck,
  output logic scan_ready
);

  logic hard_sync;
  logic any_soft;
  logic in_reset;
  rst_seq_pkg::seq_state_e state_r;
  rst_seq_pkg::seq_state_e state_nxt;
  logic [15:0] hold_cnt_r;
  logic out_n_r;
  rst_seq_pkg::core_ctl_s ctl_r;
  logic safe_r;
  logic tck_q_r;
  logic tck_rise;
  logic scan_live_r;

  // Soft reset decode, shared by the sequencer and its checks
  function automatic logic soft_any(input rst_seq_pkg::soft_req_s req);
    return req.sleep | req.watchdog | req.pin;
  endfunction

  // Hard reset level crosses in through two flops before release uses it
  rst_sync #(
    .STAGES(rst_seq_pkg::SYNC_STAGES)
  ) u_sync (
    .clk_sys(clk_sys),
    .async_in(hard_reset_n),
    .sync_out(hard_sync)
  );

  assign any_soft = soft_any(soft_req);
  // Raw pin gates too, so reset takes hold at once; release waits for the synchroniser
  assign in_reset = ~rst_b | ~hard_reset_n | ~hard_sync;

  // Next-state decode
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      rst_seq_pkg::ST_HELD:
        state_nxt = rst_seq_pkg::ST_RELEASE;
      rst_seq_pkg::ST_RELEASE:
        if (hold_cnt_r == 16'h0000)
          state_nxt = rst_seq_pkg::ST_RUN;
      rst_seq_pkg::ST_RUN:
        if (any_soft)
          state_nxt = rst_seq_pkg::ST_SOFT;
      rst_seq_pkg::ST_SOFT:
        if (!any_soft)
          state_nxt = rst_seq_pkg::ST_RELEASE;
      default:
        state_nxt = rst_seq_pkg::ST_HELD;
    endcase
  end

  // State register; hard reset overrides everything
  always_ff @(posedge clk_sys)
  begin
    if (in_reset)
      state_r <= rst_seq_pkg::ST_HELD;
    else
      state_r <= state_nxt;
  end

  // Hold counter keeps reset-out low a few cycles after release
  always_ff @(posedge clk_sys)
  begin
    if (in_reset || state_r == rst_seq_pkg::ST_SOFT)
      hold_cnt_r <= 16'(HOLD_CYC);
    else if (state_r == rst_seq_pkg::ST_RELEASE && hold_cnt_r != 16'h0000)
      hold_cnt_r <= hold_cnt_r - 16'h0001;
  end

  // Reset-out from a flop; release precedes fetch enable by one cycle
  always_ff @(posedge clk_sys)
  begin
    if (in_reset)
      out_n_r <= 1'b0;
    else if (state_nxt == rst_seq_pkg::ST_SOFT || any_soft)
      out_n_r <= 1'b0;
    else if (state_r == rst_seq_pkg::ST_RELEASE && hold_cnt_r == 16'h0000)
      out_n_r <= 1'b1;
  end

  // Core control: held with fetch off during reset, restart at vector zero
  always_ff @(posedge clk_sys)
  begin
    if (in_reset)
    begin
      ctl_r.core_reset <= 1'b1;
      ctl_r.fetch_enable <= 1'b0;
      ctl_r.fetch_addr <= rst_seq_pkg::RESET_VECTOR;
    end
    else if (state_r == rst_seq_pkg::ST_SOFT || state_r == rst_seq_pkg::ST_HELD)
    begin
      ctl_r.core_reset <= 1'b1;
      ctl_r.fetch_enable <= 1'b0;
      ctl_r.fetch_addr <= rst_seq_pkg::RESET_VECTOR;
    end
    else if (state_r == rst_seq_pkg::ST_RUN && out_n_r)
    begin
      // Fetch only once reset-out is already high
      ctl_r.core_reset <= 1'b0;
      ctl_r.fetch_enable <= 1'b1;
      ctl_r.fetch_addr <= fetch_start ? ctl_r.fetch_addr : rst_seq_pkg::RESET_VECTOR;
    end
  end

  // GPIO safe state forced during any reset, held until the core reports its first fetch
  always_ff @(posedge clk_sys)
  begin
    if (in_reset || state_r == rst_seq_pkg::ST_SOFT)
      safe_r <= 1'b1;
    else if (fetch_start)
      safe_r <= 1'b0;
  end

  assign core_ctl = ctl_r;
  assign system_reset_out_n = out_n_r;
  assign gpio_force_safe = safe_r;
  assign gpio_dir_out = '0;

  // One enable per pin; a buffer stays off while the pin is held safe, to avoid leakage
  for (genvar g = 0; g < NGPIO; g++)
  begin : g_pin
    assign gpio_inbuf_en[g] = ~safe_r;
  end

  // Test clock pin sample; taken in reset too, so a clock already high is no edge
  always_ff @(posedge clk_sys)
  begin
    tck_q_r <= tck;
  end

  // One-cycle enable on each test clock rise; the test port runs only at that rate
  assign tck_rise = tck & ~tck_q_r;

  // Test port leaves reset only on a test clock edge; hard reset or a low trst_n clears it
  always_ff @(posedge clk_sys)
  begin
    if (in_reset || !trst_n)
      scan_live_r <= 1'b0;
    else if (tck_rise)
      scan_live_r <= 1'b1;
  end

  assign scan_ready = scan_live_r;

  // Assertions
  sequence s_release;
    $rose(hard_sync) ##1 rst_b;
  endsequence

  sequence s_tck_rise;
    !tck ##1 tck;
  endsequence

  AST_HELD_NO_FETCH: assert property (@(posedge clk_sys)
    !hard_reset_n |=> !core_ctl.fetch_enable)
    else $error("fetch enabled during hard reset");

  AST_OUT_LOW_IN_RESET: assert property (@(posedge clk_sys)
    !hard_reset_n |=> !system_reset_out_n)
    else $error("reset out high during hard reset");

  AST_OUT_BEFORE_FETCH: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(core_ctl.fetch_enable) |-> $past(system_reset_out_n))
    else $error("fetch began before reset out release");

  AST_VECTOR_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(core_ctl.fetch_enable) |-> core_ctl.fetch_addr == 32'h0000_0000)
    else $error("restart not at address zero");

  AST_CORE_RESET: assert property (@(posedge clk_sys)
    !hard_reset_n |=> core_ctl.core_reset)
    else $error("core not held in reset");

  AST_SOFT_OUT: assert property (@(posedge clk_sys) disable iff (!rst_b || !hard_reset_n)
    soft_any(soft_req) |=> !system_reset_out_n)
    else $error("soft reset did not assert reset out");

  AST_GPIO_SAFE: assert property (@(posedge clk_sys)
    !hard_reset_n |=> (gpio_inbuf_en == '0 && gpio_dir_out == '0))
    else $error("gpio not safe after reset");

  AST_RELEASE_BOUND: assert property (@(posedge clk_sys) disable iff (!rst_b || !hard_reset_n)
    s_release ##0 !soft_any(soft_req) [*4]
    |-> ##[1:8] system_reset_out_n)
    else $error("reset out not released in time");

  AST_SCAN_HELD: assert property (@(posedge clk_sys)
    !hard_reset_n |=> !scan_ready)
    else $error("test port not held in reset");

  AST_SCAN_ON_TCK: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_tck_rise ##0 (trst_n && !in_reset) |=> scan_ready)
    else $error("test clock edge not taken");

  AST_SCAN_ONLY_TCK: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(scan_ready) |-> ($past(tck) && !$past(tck, 2)))
    else $error("test port left reset without a test clock edge");

endmodule
`default_nettype wire

// file: dv/core_model.sv
// Core-side partner: answers fetch permission with a first-fetch report.
// Assumes fetch_enable is registered on clk_sys; lat sets response delay.
`timescale 1ns/1ns
`default_nettype none
module core_model (
  // Clock
  input wire logic clk_sys,
  // Permission and delay
  input wire logic fetch_enable,
  input wire logic [31:0] lat,
  // First fetch report
  output logic fetch_start
);
  // A slow core may see permission drop meanwhile, so it reports only if still allowed
  initial
  begin
    fetch_start = 1'b0;
    forever
    begin
      @(posedge clk_sys iff fetch_enable === 1'b1);
      repeat (lat) @(posedge clk_sys);
      fetch_start <= fetch_enable;
      @(posedge clk_sys);
      fetch_start <= 1'b0;
      @(posedge clk_sys iff fetch_enable !== 1'b1);
    end
  end
endmodule
`default_nettype wire

// file: dv/tb.sv
// Testbench for the reset sequencer: hard and soft resets, release order.
// Assumes the default NGPIO of 81 and a 10 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic hard_reset_n = 1'b0;
  rst_seq_pkg::soft_req_s soft_req = '0;
  rst_seq_pkg::core_ctl_s core_ctl;
  logic fetch_start;
  logic system_reset_out_n;
  logic [80:0] gpio_dir_out;
  logic [80:0] gpio_inbuf_en;
  logic gpio_force_safe;
  logic scan_ready;
  logic [31:0] lat = 32'h1;
  logic tck = 1'b0;
  logic trst_n = 1'b0;
  logic fe_q = 1'b0;
  logic on_q = 1'b0;
  logic [31:0] note_q[$];
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int low_cnt = 0;
  rst_seq dut (.clk_sys(clk_sys), .rst_b(rst_b), .hard_reset_n(hard_reset_n),
    .soft_req(soft_req), .core_ctl(core_ctl), .fetch_start(fetch_start),
    .system_reset_out_n(system_reset_out_n), .gpio_dir_out(gpio_dir_out),
    .gpio_inbuf_en(gpio_inbuf_en), .gpio_force_safe(gpio_force_safe), .trst_n(trst_n),
    .tck(tck), .scan_ready(scan_ready));
  core_model core (.clk_sys(clk_sys), .fetch_enable(core_ctl.fetch_enable),
    .lat(lat), .fetch_start(fetch_start));
  // Clock
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Bounded wait for fetch permission, then let the core answer
  task automatic wait_run();
    int k;
    k = 0;
    while (core_ctl.fetch_enable !== 1'b1 && k < 40)
    begin
      @(posedge clk_sys);
      k++;
    end
    repeat (lat + 2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("inbuf_en", 1, {31'h0, &gpio_inbuf_en});
    chk("force_safe", 0, {31'h0, gpio_force_safe});
    @(posedge clk_sys);
  endtask
  // One test clock rise must bring the test port out of reset
  task automatic scan_pulse();
    @(negedge clk_sys);
    chk("scan_ready", 0, {31'h0, scan_ready});
    @(posedge clk_sys);
    tck <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("scan_ready", 1, {31'h0, scan_ready});
    @(posedge clk_sys);
    tck <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic hard_pulse(input int n);
    note_q.push_back(32'h0000_0000);
    hard_reset_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    hard_reset_n <= 1'b1;
    wait_run();
  endtask
  task automatic soft_pulse(input int which, input int n);
    note_q.push_back(32'h0000_0000);
    soft_req <= 3'(1 << which);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("reset_out_n", 0, {31'h0, system_reset_out_n});
    chk("force_safe", 1, {31'h0, gpio_force_safe});
    repeat (n) @(posedge clk_sys);
    soft_req <= '0;
    wait_run();
  endtask
  // Monitor: each rise of fetch permission consumes the oldest note
  always @(negedge clk_sys)
  begin
    cyc++;
    low_cnt = hard_reset_n ? 0 : low_cnt + 1;
    chk("dir_out", 0, {31'h0, |gpio_dir_out});
    if (low_cnt > 3 && rst_b)
    begin
      chk("reset_out_n", 0, {31'h0, system_reset_out_n});
      chk("fetch_enable", 0, {31'h0, core_ctl.fetch_enable});
      chk("core_reset", 1, {31'h0, core_ctl.core_reset});
      chk("scan_ready", 0, {31'h0, scan_ready});
      chk("inbuf_en", 0, {31'h0, |gpio_inbuf_en});
    end
    if (system_reset_out_n === 1'b1 && on_q === 1'b0)
      chk("fetch_at_release", 0, {31'h0, core_ctl.fetch_enable});
    if (core_ctl.fetch_enable === 1'b1 && fe_q !== 1'b1)
    begin
      if (note_q.size() == 0)
        chk("note", 1, 0);
      else
        chk("fetch_addr", note_q.pop_front(), core_ctl.fetch_addr);
      chk("reset_out_n", 1, {31'h0, system_reset_out_n});
      chk("core_reset", 0, {31'h0, core_ctl.core_reset});
      chk("inbuf_en", 0, {31'h0, |gpio_inbuf_en});
    end
    fe_q = core_ctl.fetch_enable;
    on_q = system_reset_out_n;
    if (cyc > 5000)
    begin
      errors++;
      print_verdict();
    end
  end
  // Main sequence; supervisor keeps hard reset low well past local reset
  initial
  begin
    void'($urandom(97664));
    note_q.push_back(32'h0000_0000);
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (9) @(posedge clk_sys);
    trst_n <= 1'b1;
    @(posedge clk_sys);
    hard_reset_n <= 1'b1;
    wait_run();
    scan_pulse();
    for (int i = 0; i < 3; i++)
      soft_pulse(i, 3);
    hard_pulse(3);
    scan_pulse();
    for (int i = 0; i < 8; i++)
    begin
      lat <= $urandom_range(1, 6);
      if ($urandom_range(0, 1) == 1)
        hard_pulse($urandom_range(3, 12));
      else
        soft_pulse($urandom_range(0, 2), $urandom_range(1, 8));
    end
    chk("notes_left", 0, note_q.size());
    print_verdict();
  end
endmodule
`default_nettype wire
